// *** src/hsu_top.v ***
// Sync unit: receive gating, break and sync timers, APB registers
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "hsu_map.vh"

// Functional notes
// R1: Mode bit: clear LIN, set pulse-width bus
// R2: LIN, gate set: hold UART input high (code passes bus data once the sync is done)
// R3: LIN, gate clear: pass bus data through
// R4: Pulse read, gate set: flag every rise
// R5: Break timer runs falling to rising edge
// R6: Break compare match and overflow raise flags
// R7: Pulse write, gate clear: no rise flag
// R8: Gate left set in write: flag on release
// R9: Software releases bus on sync compare flag
// R10: Write mode break timer stops on rise
// R11: Stop bit set: sync stops on rises
// R12: Stop bit clear: sync stops on falls
// R13: Control bits read/write, act next edge
module hsu_top #(
  parameter TW = 16
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata_reg,
  output reg         pready_reg,
  output reg         pslverr_reg,
  input  wire        bus_rxd,
  output reg         uart_rxd_reg,
  output reg         irq_reg
);

  // One-hot sequence states
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_BRK  = 4'b0010;
  localparam [3:0] ST_SYNC = 4'b0100;
  localparam [3:0] ST_DONE = 4'b1000;

  // Control and configuration
  reg          gate_reg;
  reg          stop_rise_reg;
  reg          mode_reg;
  reg [3:0]    ecnt_reg;
  reg [TW-1:0] brk_cmp_reg;
  reg [TW-1:0] sync_cmp_reg;
  reg [`HSU_ST_W-1:0] int_en_reg;
  reg [`HSU_ST_W-1:0] status_reg;
  reg [`HSU_ST_W-1:0] status_next;
  reg [`HSU_ST_W-1:0] ev;
  reg [`HSU_ST_W-1:0] clr_mask;

  // Line and sequence state
  reg          rxd_d_reg;
  reg          brk_run_reg;
  reg          brk_hit_seen_reg;
  reg [3:0]    state_reg;
  reg [3:0]    state_next;
  reg [3:0]    edges_reg;
  reg [3:0]    edges_next;
  reg          sync_clr;
  reg          sync_end;

  // APB decode
  reg [31:0]   rd_mux;
  reg          addr_hit;
  wire         setup;
  wire         wr;

  // Timer taps
  wire [TW-1:0] brk_count;
  wire          brk_hit;
  wire          brk_ovf;
  wire [TW-1:0] sync_count;
  wire          sync_hit;
  wire          sync_ovf;

  // Edge detection
  wire fall;
  wire rise;
  wire stop_edge;
  wire brk_valid;
  wire sync_run;

  assign fall = rxd_d_reg & ~bus_rxd;
  assign rise = ~rxd_d_reg & bus_rxd;

  // Selected edge type ends the sync measurement
  assign stop_edge = stop_rise_reg ? rise : fall;  // R11 R12

  // LIN break: low pulse that reached the compare value
  assign brk_valid = rise & brk_run_reg & (brk_hit_seen_reg | brk_hit);

  assign sync_run = state_reg[2];

  assign setup = psel & ~penable;
  assign wr    = psel & penable & pready_reg & pwrite;

  // Break timer restarts on fall, halts on rise in every mode
  hsu_timer #(
    .W (TW)
  ) u_brk (
    .clk       (pclk),
    .rst_n     (presetn),
    .clr       (fall),
    .run       (brk_run_reg & ~rise),
    .cmp       (brk_cmp_reg),
    .count_reg (brk_count),
    .hit_reg   (brk_hit),
    .ovf_reg   (brk_ovf)
  );  // R5 R10

  // Sync timer runs only while the sync sequence is measured
  hsu_timer #(
    .W (TW)
  ) u_sync (
    .clk       (pclk),
    .rst_n     (presetn),
    .clr       (sync_clr),
    .run       (sync_run & ~sync_end),
    .cmp       (sync_cmp_reg),
    .count_reg (sync_count),
    .hit_reg   (sync_hit),
    .ovf_reg   (sync_ovf)
  );

  // Break pulse tracking
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_d_reg        <= 1'b1;
      brk_run_reg      <= 1'b0;
      brk_hit_seen_reg <= 1'b0;
    end else begin
      rxd_d_reg <= bus_rxd;
      if (fall) begin
        brk_run_reg      <= 1'b1;  // R5
        brk_hit_seen_reg <= 1'b0;
      end else begin
        if (rise) begin
          brk_run_reg <= 1'b0;  // R5 R10
        end
        if (brk_hit) begin
          brk_hit_seen_reg <= 1'b1;
        end
      end
    end
  end

  // Sequence: break, then edge-counted sync measurement
  always @* begin
    state_next = state_reg;
    edges_next = edges_reg;
    sync_clr   = 1'b0;
    sync_end   = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (mode_reg && fall) begin
          // Pulse-width bus: a low pulse that starts in idle opens a measurement
          state_next = ST_SYNC;
          edges_next = 4'h0;
          sync_clr   = 1'b1;
        end else if (!mode_reg && brk_valid) begin
          state_next = ST_BRK;  // R1
        end
      end
      ST_BRK: begin
        if (fall) begin
          state_next = ST_SYNC;
          edges_next = 4'h0;
          sync_clr   = 1'b1;
        end
      end
      ST_SYNC: begin
        if (stop_edge) begin
          edges_next = edges_reg + 4'h1;
          // Zero in the field means sixteen edges
          if (edges_next == ecnt_reg) begin
            sync_end   = 1'b1;  // R11 R12
            state_next = mode_reg ? ST_IDLE : ST_DONE;
          end
        end
      end
      ST_DONE: begin
        // Pulse-width bus must not stay parked after a LIN sequence
        if (mode_reg && fall) begin
          state_next = ST_SYNC;
          edges_next = 4'h0;
          sync_clr   = 1'b1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // A fresh LIN break restarts the whole sequence
    if (!mode_reg && brk_valid) begin
      state_next = ST_BRK;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      edges_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      edges_reg <= edges_next;
    end
  end

  // Events that set sticky status bits
  always @* begin
    ev = {`HSU_ST_W{1'b0}};
    if (mode_reg) begin
      // Gate bit enables the rise flag in both bus directions
      ev[`HSU_ST_BRK] = rise & brk_run_reg & gate_reg;  // R4 R7 R8
    end else begin
      ev[`HSU_ST_BRK] = brk_valid;
    end
    ev[`HSU_ST_BRK_CMP]  = brk_hit;  // R6
    ev[`HSU_ST_BRK_OVF]  = brk_ovf | sync_ovf;  // R6
    ev[`HSU_ST_SYNC_CMP] = sync_hit;  // R9
    ev[`HSU_ST_SYNC_END] = sync_end;
  end

  // Set wins over a clear in the same cycle
  always @* begin
    clr_mask = {`HSU_ST_W{1'b0}};
    if (wr && paddr == `HSU_OFF_INT_CLR) begin
      clr_mask = pwdata[`HSU_ST_W-1:0];
    end
    status_next = (status_reg & ~clr_mask) | ev;
  end

  // Register writes land on the access edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_reg      <= `HSU_RST_GATE;
      stop_rise_reg <= `HSU_RST_STOP;
      mode_reg      <= `HSU_RST_MODE;
      ecnt_reg      <= `HSU_RST_ECNT;
      brk_cmp_reg   <= {TW{1'b1}};
      sync_cmp_reg  <= {TW{1'b1}};
      int_en_reg    <= `HSU_RST_EN;
      status_reg    <= `HSU_RST_ST;
    end else begin
      status_reg <= status_next;
      if (wr) begin
        case (paddr)
          `HSU_OFF_CTRL0: begin
            gate_reg      <= pwdata[`HSU_C0_GATE];  // R13
            stop_rise_reg <= pwdata[`HSU_C0_STOP];  // R13
            mode_reg      <= pwdata[`HSU_C0_MODE];  // R1
          end
          `HSU_OFF_CTRL1: begin
            ecnt_reg <= pwdata[`HSU_C1_ECNT_HI:`HSU_C1_ECNT_LO];
          end
          `HSU_OFF_BRK: begin
            brk_cmp_reg <= pwdata[TW-1:0];  // R6
          end
          `HSU_OFF_SYNC_CMP: begin
            sync_cmp_reg <= pwdata[TW-1:0];
          end
          `HSU_OFF_INT_EN: begin
            int_en_reg <= pwdata[`HSU_ST_W-1:0];
          end
          default: begin
            int_en_reg <= int_en_reg;
          end
        endcase
      end
    end
  end

  // Read mux; reserved bits read as zero
  always @* begin
    rd_mux   = 32'h0000_0000;
    addr_hit = 1'b1;
    case (paddr)
      `HSU_OFF_CTRL0: begin
        rd_mux[`HSU_C0_GATE] = gate_reg;  // R13
        rd_mux[`HSU_C0_STOP] = stop_rise_reg;  // R13
        rd_mux[`HSU_C0_MODE] = mode_reg;
      end
      `HSU_OFF_CTRL1: begin
        rd_mux[`HSU_C1_ECNT_HI:`HSU_C1_ECNT_LO] = ecnt_reg;
      end
      `HSU_OFF_BRK: begin
        rd_mux[TW-1:0] = brk_count;  // R5
      end
      `HSU_OFF_SYNC: begin
        rd_mux[TW-1:0] = sync_count;
      end
      `HSU_OFF_SYNC_CMP: begin
        rd_mux[TW-1:0] = sync_cmp_reg;
      end
      `HSU_OFF_STATUS: begin
        rd_mux[`HSU_ST_W-1:0] = status_reg;
      end
      `HSU_OFF_INT_CLR: begin
        rd_mux = 32'h0000_0000;  // Write-only
      end
      `HSU_OFF_INT_EN: begin
        rd_mux[`HSU_ST_W-1:0] = int_en_reg;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // One wait-free access cycle; data captured at setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup & ~addr_hit;
      if (setup && !pwrite) begin
        prdata_reg <= rd_mux;
      end
    end
  end

  // Receive gating; gate released once sync is done
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uart_rxd_reg <= 1'b1;
      irq_reg      <= 1'b0;
    end else begin
      if (!mode_reg && gate_reg && state_reg != ST_DONE) begin
        uart_rxd_reg <= 1'b1;  // R2
      end else begin
        uart_rxd_reg <= bus_rxd;  // R3
      end
      irq_reg <= |(status_next & int_en_reg);
    end
  end

endmodule

`default_nettype wire

// *** src/hsu_map.vh ***
// Register offsets, field positions and reset values of the sync unit
`ifndef HSU_MAP_VH
`define HSU_MAP_VH

// Byte offsets of the registers
`define HSU_OFF_CTRL0    8'h00
`define HSU_OFF_CTRL1    8'h04
`define HSU_OFF_BRK      8'h08
`define HSU_OFF_SYNC     8'h0c
`define HSU_OFF_SYNC_CMP 8'h10
`define HSU_OFF_STATUS   8'h14
`define HSU_OFF_INT_CLR  8'h18
`define HSU_OFF_INT_EN   8'h1c

// Control word 0 fields
`define HSU_C0_GATE 8
`define HSU_C0_STOP 7
`define HSU_C0_MODE 6

// Control word 1 edge-count field
`define HSU_C1_ECNT_HI 7
`define HSU_C1_ECNT_LO 4

// Status, clear and enable bits
`define HSU_ST_BRK      0
`define HSU_ST_BRK_CMP  1
`define HSU_ST_BRK_OVF  2
`define HSU_ST_SYNC_CMP 3
`define HSU_ST_SYNC_END 4
`define HSU_ST_W        5

// Reset values
`define HSU_RST_GATE  1'b0
`define HSU_RST_STOP  1'b0
`define HSU_RST_MODE  1'b0
`define HSU_RST_ECNT  4'h0
`define HSU_RST_ST    5'h00
`define HSU_RST_EN    5'h00

`endif

// *** src/hsu_timer.v ***
// Up counter gated by run, with clear, compare hit and overflow pulses
`timescale 1ns/100ps
`default_nettype none

module hsu_timer #(
  parameter W = 16
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         clr,
  input  wire         run,
  input  wire [W-1:0] cmp,
  output reg  [W-1:0] count_reg,
  output reg          hit_reg,
  output reg          ovf_reg
);

  wire [W-1:0] one;
  wire [W-1:0] count_next;

  assign one        = {{(W-1){1'b0}}, 1'b1};
  assign count_next = count_reg + one;

  // Clear beats run so a restart never counts the old pulse
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= {W{1'b0}};
      hit_reg   <= 1'b0;
      ovf_reg   <= 1'b0;
    end else if (clr) begin
      count_reg <= {W{1'b0}};
      hit_reg   <= 1'b0;
      ovf_reg   <= 1'b0;
    end else if (run) begin
      count_reg <= count_next;
      hit_reg   <= (count_next == cmp);
      ovf_reg   <= &count_reg;  // Wraps to zero
    end else begin
      hit_reg   <= 1'b0;
      ovf_reg   <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// *** test/hsu_top_chk.sv ***
// Port-level checker for the sync unit
`timescale 1ns/100ps
`default_nettype none
module hsu_top_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata_reg,
  input wire logic        pready_reg,
  input wire logic        pslverr_reg,
  input wire logic        bus_rxd,
  input wire logic        uart_rxd_reg,
  input wire logic        irq_reg
);
  logic       gate_q;
  logic       mode_q;
  logic [4:0] en_q;
  wire        wr_acc = psel && penable && pready_reg && pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow of control bits, same commit edge as the design
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_q <= 1'b0;
      mode_q <= 1'b0;
      en_q   <= 5'h00;
    end else if (wr_acc && paddr == 8'h00) begin
      gate_q <= pwdata[8];
      mode_q <= pwdata[6];
    end else if (wr_acc && paddr == 8'h1c) begin
      en_q <= pwdata[4:0];
    end
  end
  // Bus handshake
  a_rdy_after_setup: assert property (psel && !penable |=> pready_reg)
    else $error("no ready after setup");
  a_rdy_single: assert property (pready_reg |=> !pready_reg)
    else $error("ready longer than one cycle");
  a_rdy_in_access: assert property (pready_reg |-> psel && penable)
    else $error("ready outside access");
  a_err_unmapped: assert property (psel && !penable |=>
    pslverr_reg == ($past(paddr) > 8'h1c || $past(paddr[1:0]) != 2'b00))
    else $error("wrong slave error");
  a_rd_data_hold: assert property (!(psel && !penable && !pwrite) |=>
    $stable(prdata_reg)) else $error("read data moved");
  // Receive path; three stable cycles cover the pipeline lag
  a_rx_pass: assert property ((!gate_q && !mode_q && $stable(bus_rxd))[*3]
    |-> uart_rxd_reg == bus_rxd) else $error("receive not passed");
  a_rx_gate_high: assert property ((gate_q && !mode_q && bus_rxd)[*3]
    |-> uart_rxd_reg) else $error("gated receive low");
  a_irq_masked: assert property ((en_q == 5'h00)[*2] |-> !irq_reg)
    else $error("interrupt while masked");
  c_slave_err: cover property (pslverr_reg);
  c_irq: cover property (irq_reg);
  c_rx_low: cover property (!mode_q && !uart_rxd_reg);
endmodule
`default_nettype wire

// *** test/hsu_bus_master.sv ***
// Bus master node driving the receive level
`timescale 1ns/100ps
`default_nettype none
module hsu_bus_master (
  input  wire logic clk,
  output var logic  line
);
  // Wire idles high; the master drives it high from time zero
  initial line = 1'b1;
  // Hold a level for n cycles; changes land just after an edge
  task automatic hold(input logic v, input int n);
    line <= v;
    repeat (n) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// *** test/lin_pulse_bus_sync_gating_tb.sv ***
// Self-checking bench for the sync unit
`timescale 1ns/100ps
`default_nettype none
`include "hsu_map.vh"
module lin_pulse_bus_sync_gating_tb;
  localparam int TW = 8;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        bus_rxd;
  logic        uart_rxd_reg;
  logic        irq_reg;
  logic [31:0] rd_q;
  logic        err_q;
  logic [31:0] c1;
  int          err_total = 0;
  int          compares = 0;
  int          seed = 19;
  int          w1;
  int          w2;
  logic [7:0]  ra[$] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h18, 8'h1c};
  // Small timer width keeps overflow reachable
  hsu_top #(.TW(TW)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_reg(prdata_reg), .pready_reg(pready_reg), .pslverr_reg(pslverr_reg),
    .bus_rxd(bus_rxd), .uart_rxd_reg(uart_rxd_reg), .irq_reg(irq_reg));
  hsu_bus_master bm_u (.clk(pclk), .line(bus_rxd));
  initial forever #4 pclk = ~pclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One transfer; an idle edge follows so no signal is set twice at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready_reg !== 1'b1);
    rd_q  = prdata_reg;
    err_q = pslverr_reg;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic st(input int b, input logic e);
    apb(1'b0, `HSU_OFF_STATUS, 32'h0);
    chk(32'(rd_q[b]), 32'(e));
  endtask
  task automatic lvl(input logic v, input int n);
    bm_u.hold(v, n);
  endtask
  task automatic complete_run;
    if (err_total == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    complete_run;
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd_q, 32'h0);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(err_q), 32'h1);
    w1 = $random(seed) & 32'h1c0;
    apb(1'b1, `HSU_OFF_CTRL0, w1);
    apb(1'b0, `HSU_OFF_CTRL0, 32'h0);
    chk(rd_q & 32'h1c0, 32'(w1));
    // LIN, gated, sync ends on the second rise
    apb(1'b1, `HSU_OFF_BRK, 32'd40);
    apb(1'b1, `HSU_OFF_CTRL1, 32'h20);
    apb(1'b1, `HSU_OFF_CTRL0, 32'h180);
    apb(1'b1, `HSU_OFF_INT_CLR, 32'h1f);
    lvl(1'b0, 50);
    chk(32'(uart_rxd_reg), 32'h1);
    lvl(1'b1, 6);
    st(`HSU_ST_BRK, 1'b1);
    lvl(1'b0, 4);
    lvl(1'b1, 6);
    st(`HSU_ST_SYNC_END, 1'b0);
    chk(32'(uart_rxd_reg), 32'h1);
    lvl(1'b0, 4);
    lvl(1'b1, 6);
    st(`HSU_ST_SYNC_END, 1'b1);
    lvl(1'b0, 4);
    chk(32'(uart_rxd_reg), 32'h0);
    lvl(1'b1, 4);
    // Falling stop: one fall alone must not end it
    apb(1'b1, `HSU_OFF_CTRL0, 32'h100);
    apb(1'b1, `HSU_OFF_INT_CLR, 32'h1f);
    lvl(1'b0, 50);
    lvl(1'b1, 6);
    lvl(1'b0, 4);
    lvl(1'b1, 4);
    lvl(1'b0, 4);
    st(`HSU_ST_SYNC_END, 1'b0);
    lvl(1'b1, 4);
    lvl(1'b0, 4);
    st(`HSU_ST_SYNC_END, 1'b1);
    lvl(1'b1, 6);
    apb(1'b1, `HSU_OFF_CTRL0, 32'h0);
    lvl(1'b0, 4);
    chk(32'(uart_rxd_reg), 32'h0);
    lvl(1'b1, 4);
    // Pulse-width bus: break flag, interrupt clear and mask, widths
    apb(1'b1, `HSU_OFF_CTRL0, 32'h140);
    apb(1'b1, `HSU_OFF_INT_CLR, 32'h1f);
    apb(1'b1, `HSU_OFF_INT_EN, 32'h1);
    w1 = 8 + ($random(seed) & 15);
    lvl(1'b0, w1);
    lvl(1'b1, 6);
    st(`HSU_ST_BRK, 1'b1);
    chk(32'(irq_reg), 32'h1);
    apb(1'b0, `HSU_OFF_BRK, 32'h0);
    c1 = rd_q;
    apb(1'b1, `HSU_OFF_INT_CLR, 32'h1);
    @(posedge pclk);
    chk(32'(irq_reg), 32'h0);
    apb(1'b1, `HSU_OFF_INT_EN, 32'h0);
    w2 = w1 + 1 + ($random(seed) & 31);
    lvl(1'b0, w2);
    lvl(1'b1, 6);
    st(`HSU_ST_BRK, 1'b1);
    chk(32'(irq_reg), 32'h0);
    apb(1'b0, `HSU_OFF_BRK, 32'h0);
    chk(rd_q - c1, 32'(w2 - w1));
    // Gate clear suppresses the rise flag; compare still flags
    apb(1'b1, `HSU_OFF_CTRL0, 32'h040);
    apb(1'b1, `HSU_OFF_BRK, 32'h5);
    apb(1'b1, `HSU_OFF_INT_CLR, 32'h1f);
    lvl(1'b0, 12);
    lvl(1'b1, 6);
    st(`HSU_ST_BRK, 1'b0);
    chk(32'(rd_q[`HSU_ST_BRK_CMP]), 32'h1);
    // Write mode: software releases the low once sync compare flags
    apb(1'b1, `HSU_OFF_SYNC_CMP, 32'h10);
    apb(1'b1, `HSU_OFF_INT_CLR, 32'h1f);
    lvl(1'b0, 1);
    w1 = 1;
    do begin
      apb(1'b0, `HSU_OFF_STATUS, 32'h0);
      w1 = w1 + 3;
    end while (rd_q[`HSU_ST_SYNC_CMP] !== 1'b1);
    lvl(1'b1, 6);
    chk(32'(w1 > 16), 32'h1);
    st(`HSU_ST_BRK, 1'b0);
    apb(1'b0, `HSU_OFF_BRK, 32'h0);
    chk(rd_q, 32'(w1 - 1));
    lvl(1'b0, 300);
    lvl(1'b1, 6);
    st(`HSU_ST_BRK_OVF, 1'b1);
    complete_run;
  end
endmodule
bind hsu_top hsu_top_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata_reg(prdata_reg), .pready_reg(pready_reg), .pslverr_reg(pslverr_reg),
  .bus_rxd(bus_rxd), .uart_rxd_reg(uart_rxd_reg), .irq_reg(irq_reg));
`default_nettype wire
